// File: qsanc_cfg_partner.sv
`timescale 1ns/1ns
module qsanc_cfg_partner
(
  input wire logic core_clk,
  output logic [23:0] config_bus,
  output logic [3:0] config_load,
  output logic [63:0] advert_settings_bus,
  output logic [3:0] advert_settings_load,
  output logic [3:0] negotiation_restart_strobe
);
  logic [11:0] s = '0;
  initial config_bus = '0;
  initial advert_settings_bus = '0;
  assign config_load = s[3:0];
  assign advert_settings_load = s[7:4];
  assign negotiation_restart_strobe = s[11:8];
  task automatic drive(input int k, input int ch, input logic [15:0] v);
    if (k == 0)
      config_bus[ch*6+:6] = v[5:0];
    else if (k == 1)
      advert_settings_bus[ch*16+:16] = v;
  endtask : drive
  // chg moves the vector while the strobe is held, which must load nothing in a build with management
  task automatic pulse(input int k, input int ch, input logic [15:0] v, input bit chg);
    @(negedge core_clk);
    drive(k, ch, v);
    s[k*4+ch] = 1'b1;
    @(negedge core_clk);
    if (chg)
    begin
      drive(k, ch, ~v);
      @(negedge core_clk);
    end
    s[k*4+ch] = 1'b0;
    @(negedge core_clk);
  endtask : pulse
endmodule : qsanc_cfg_partner

// File: qsanc_channel.sv
`timescale 1ns/1ns
module qsanc_channel
  import qsanc_pkg::*;
#(
  parameter bit has_mdio = 1'b1,
  parameter bit has_an = 1'b1,
  parameter bit mac_mode = 1'b0,
  parameter bit is_ch0 = 1'b0,
  parameter int timer_unit = qsanc_timer_unit_count
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [8:0] link_timer_value,
  input wire logic [5:0] config_bus,
  input wire logic config_load,
  input wire logic [15:0] advert_settings_bus,
  input wire logic advert_settings_load,
  input wire logic negotiation_restart_strobe,
  input wire logic mgmt_wr,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] ctrl_value,
  output logic [15:0] autoneg_advert,
  output logic negotiation_done_irq,
  output logic unidir_enable,
  output logic power_down,
  output logic gmii_isolate,
  output logic an_enable,
  output logic an_busy
);
  logic cfg_q, adv_q, rst_q;
  logic next_cfg_q, next_adv_q, next_rst_q;
  logic [15:0] ctrl, next_ctrl, adv, next_adv;
  logic [8:0] units, next_units;
  logic [12:0] cyc, next_cyc;
  logic busy, next_busy, done, next_done, irq_flag, next_irq_flag;
  logic cfg_rise, adv_rise, rst_rise, restart, ctrl_wr, adv_wr;
  logic [15:0] cfg_as_ctrl;

  always_comb
  begin
    cfg_rise = config_load && !cfg_q;
    adv_rise = advert_settings_load && !adv_q;
    rst_rise = has_an && negotiation_restart_strobe && !rst_q;
    ctrl_wr = mgmt_wr && mgmt_addr == qsanc_ctrl_offset;
    adv_wr = mgmt_wr && mgmt_addr == qsanc_advert_offset;
    cfg_as_ctrl = ctrl;
    cfg_as_ctrl[qsanc_ctrl_unidir_bit] = config_bus[qsanc_cfg_unidir_bit];
    cfg_as_ctrl[qsanc_ctrl_isolate_bit] = config_bus[qsanc_cfg_isolate_bit];
    cfg_as_ctrl[qsanc_ctrl_an_enable_bit] = has_an && config_bus[qsanc_cfg_an_enable_bit];
    // power-down latches: once set only reset clears it
    cfg_as_ctrl[qsanc_ctrl_power_down_bit] = ctrl[qsanc_ctrl_power_down_bit] ||
      (is_ch0 && config_bus[qsanc_cfg_power_down_bit]);
    next_cfg_q = config_load;
    next_adv_q = advert_settings_load;
    next_rst_q = negotiation_restart_strobe;
    next_ctrl = ctrl;
    if (!has_mdio)
      next_ctrl = cfg_as_ctrl;
    else if (cfg_rise)
      next_ctrl = cfg_as_ctrl;
    else if (ctrl_wr)
    begin
      next_ctrl = mgmt_wdata;
      next_ctrl[qsanc_ctrl_power_down_bit] = ctrl[qsanc_ctrl_power_down_bit] ||
        (is_ch0 && mgmt_wdata[qsanc_ctrl_power_down_bit]);
    end
    next_ctrl[qsanc_ctrl_irq_clear_bit] = 1'b0;
    next_ctrl[qsanc_ctrl_restart_bit] = rst_rise ||
      (has_mdio && ctrl_wr && !cfg_rise && mgmt_wdata[qsanc_ctrl_restart_bit]);
    next_adv = adv;
    if (mac_mode)
      next_adv = qsanc_advert_mac_mode;
    else if (!has_mdio || adv_rise || adv_wr)
    begin
      next_adv = (has_mdio && !adv_rise) ? mgmt_wdata : advert_settings_bus;
      next_adv[qsanc_adv_always_one_bit] = 1'b1;
    end
    restart = ctrl[qsanc_ctrl_restart_bit];
    next_units = units;
    next_cyc = cyc;
    next_busy = busy;
    next_done = done;
    if (restart || !ctrl[qsanc_ctrl_an_enable_bit])
    begin
      next_busy = restart && ctrl[qsanc_ctrl_an_enable_bit];
      next_done = 1'b0;
      next_units = link_timer_value;
      next_cyc = '0;
    end
    else if (busy)
    begin
      // busy lasts setting x timer_unit cycles (4096 by default) plus one
      if (units == '0)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      else if (cyc == 13'(timer_unit - 1))
      begin
        next_cyc = '0;
        next_units = units - 9'h001;
      end
      else
        next_cyc = cyc + 13'h0001;
    end
    next_irq_flag = irq_flag;
    if (busy && next_done)
      next_irq_flag = 1'b1;
    else if (ctrl_wr && mgmt_wdata[qsanc_ctrl_irq_clear_bit])
      next_irq_flag = 1'b0;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_q <= 1'b0;
      adv_q <= 1'b0;
      rst_q <= 1'b0;
      ctrl <= qsanc_ctrl_reset;
      adv <= qsanc_advert_reset;
      units <= '0;
      cyc <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      irq_flag <= 1'b0;
    end
    else
    begin
      cfg_q <= next_cfg_q;
      adv_q <= next_adv_q;
      rst_q <= next_rst_q;
      ctrl <= next_ctrl;
      adv <= next_adv;
      units <= next_units;
      cyc <= next_cyc;
      busy <= next_busy;
      done <= next_done;
      irq_flag <= next_irq_flag;
    end
  end

  assign ctrl_value = ctrl;
  assign autoneg_advert = adv;
  assign negotiation_done_irq = has_mdio ? (irq_flag && ctrl[qsanc_ctrl_irq_enable_bit]) : done;
  assign unidir_enable = ctrl[qsanc_ctrl_unidir_bit];
  assign power_down = ctrl[qsanc_ctrl_power_down_bit];
  assign gmii_isolate = ctrl[qsanc_ctrl_isolate_bit];
  assign an_enable = ctrl[qsanc_ctrl_an_enable_bit];
  assign an_busy = busy;
endmodule : qsanc_channel

// File: qsanc_config_port.sv
`timescale 1ns/1ns
module qsanc_config_port
  import qsanc_pkg::*;
#(
  parameter bit has_mdio = 1'b1,
  parameter bit has_an = 1'b1,
  parameter bit mac_mode = 1'b0,
  parameter int timer_unit = qsanc_timer_unit_count
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [qsanc_channels*9-1:0] link_timer_value,
  input wire logic [qsanc_channels*6-1:0] config_bus,
  input wire logic [qsanc_channels-1:0] config_load,
  input wire logic [qsanc_channels*16-1:0] advert_settings_bus,
  input wire logic [qsanc_channels-1:0] advert_settings_load,
  input wire logic [qsanc_channels-1:0] negotiation_restart_strobe,
  input wire logic [qsanc_channels-1:0] mgmt_wr,
  input wire logic [qsanc_channels*5-1:0] mgmt_addr,
  input wire logic [qsanc_channels*16-1:0] mgmt_wdata,
  output logic [qsanc_channels*16-1:0] ctrl_value,
  output logic [qsanc_channels*16-1:0] autoneg_advert,
  output logic [qsanc_channels-1:0] negotiation_done_irq,
  output logic [qsanc_channels-1:0] unidir_enable,
  output logic [qsanc_channels-1:0] power_down,
  output logic [qsanc_channels-1:0] gmii_isolate,
  output logic [qsanc_channels-1:0] an_enable,
  output logic [qsanc_channels-1:0] an_busy
);
  for (genvar ch = 0; ch < qsanc_channels; ch++)
  begin : g_ch
    qsanc_channel #(
      .has_mdio(has_mdio),
      .has_an(has_an),
      .mac_mode(mac_mode),
      .is_ch0(ch == 0),
      .timer_unit(timer_unit)
    ) u_ch (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .link_timer_value(link_timer_value[ch*9 +: 9]),
      .config_bus(config_bus[ch*6 +: 6]),
      .config_load(config_load[ch]),
      .advert_settings_bus(advert_settings_bus[ch*16 +: 16]),
      .advert_settings_load(advert_settings_load[ch]),
      .negotiation_restart_strobe(negotiation_restart_strobe[ch]),
      .mgmt_wr(mgmt_wr[ch]),
      .mgmt_addr(mgmt_addr[ch*5 +: 5]),
      .mgmt_wdata(mgmt_wdata[ch*16 +: 16]),
      .ctrl_value(ctrl_value[ch*16 +: 16]),
      .autoneg_advert(autoneg_advert[ch*16 +: 16]),
      .negotiation_done_irq(negotiation_done_irq[ch]),
      .unidir_enable(unidir_enable[ch]),
      .power_down(power_down[ch]),
      .gmii_isolate(gmii_isolate[ch]),
      .an_enable(an_enable[ch]),
      .an_busy(an_busy[ch])
    );

    // a held strobe loads only once
    a_single_load_edge: assert property (@(posedge core_clk) disable iff (!arst_n)
      (has_mdio && !mac_mode && config_load[ch] && $past(config_load[ch]) &&
       !mgmt_wr[ch]) |=> $stable(ctrl_value[ch*16+10 +: 3]))
      else $error("held config load reloaded control");
    a_advert_load: assert property (@(posedge core_clk) disable iff (!arst_n)
      (has_mdio && !mac_mode && $rose(advert_settings_load[ch])) |=>
      autoneg_advert[ch*16+1 +: 15] == $past(advert_settings_bus[ch*16+1 +: 15]))
      else $error("advert load not applied");
    a_advert_bit0: assert property (@(posedge core_clk) disable iff (!arst_n)
      autoneg_advert[ch*16] == 1'b1)
      else $error("advert bit 0 not one");
    a_mac_fixed: assert property (@(posedge core_clk) disable iff (!arst_n)
      mac_mode |-> autoneg_advert[ch*16 +: 16] == qsanc_advert_mac_mode)
      else $error("mac mode advert not fixed");
    a_power_latch: assert property (@(posedge core_clk) disable iff (!arst_n)
      power_down[ch] |=> power_down[ch])
      else $error("power down released without reset");
    a_power_ch_only: assert property (@(posedge core_clk) disable iff (!arst_n)
      (ch != 0) |-> !power_down[ch])
      else $error("power down on other channel");
    a_restart_busy: assert property (@(posedge core_clk) disable iff (!arst_n)
      (has_an && $rose(negotiation_restart_strobe[ch]) && an_enable[ch] && !config_load[ch] &&
       !mgmt_wr[ch]) |-> ##2 an_busy[ch])
      else $error("restart did not start timer");
    a_done_drops: assert property (@(posedge core_clk) disable iff (!arst_n)
      (!has_mdio && an_busy[ch]) |-> !negotiation_done_irq[ch])
      else $error("done shown while negotiating");
  end
endmodule : qsanc_config_port

// File: qsanc_config_port_tb.sv
`timescale 1ns/1ns
module qsanc_config_port_tb;
  import qsanc_pkg::*;
  localparam int tu = 4;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [35:0] link_timer_value = '0;
  logic [3:0] mgmt_wr = '0;
  logic [19:0] mgmt_addr = '0;
  logic [63:0] mgmt_wdata = '0;
  wire [23:0] config_bus;
  wire [3:0] config_load, advert_settings_load, negotiation_restart_strobe;
  wire [63:0] advert_settings_bus, ctrl_value, autoneg_advert;
  wire [3:0] negotiation_done_irq, unidir_enable, power_down, gmii_isolate, an_enable, an_busy;
  wire [63:0] nm_ctrl, nm_advert;
  wire [3:0] nm_irq, nm_unidir, nm_pd, nm_iso, nm_an, nm_busy;
  int n_mismatch = 0;
  int compares = 0;
  int n;
  int c;
  logic [31:0] seed = 32'h756a5f97;
  logic pd0 = 1'b0;
  logic [15:0] v;
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  qsanc_cfg_partner u_far(.core_clk, .config_bus, .config_load, .advert_settings_bus,
    .advert_settings_load, .negotiation_restart_strobe);
  qsanc_config_port #(.timer_unit(tu)) u_dut(.core_clk, .arst_n, .link_timer_value,
    .config_bus, .config_load, .advert_settings_bus, .advert_settings_load,
    .negotiation_restart_strobe, .mgmt_wr, .mgmt_addr, .mgmt_wdata, .ctrl_value,
    .autoneg_advert, .negotiation_done_irq, .unidir_enable, .power_down, .gmii_isolate,
    .an_enable, .an_busy);
  // second build without management: vectors act as live registers
  qsanc_config_port #(.has_mdio(1'b0), .timer_unit(tu)) u_dut_nm(.core_clk, .arst_n,
    .link_timer_value, .config_bus, .config_load, .advert_settings_bus, .advert_settings_load,
    .negotiation_restart_strobe, .mgmt_wr, .mgmt_addr, .mgmt_wdata, .ctrl_value(nm_ctrl),
    .autoneg_advert(nm_advert), .negotiation_done_irq(nm_irq), .unidir_enable(nm_unidir),
    .power_down(nm_pd), .gmii_isolate(nm_iso), .an_enable(nm_an), .an_busy(nm_busy));
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction : rnd
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // extra cycle lets the registered interrupt settle before any check
  task automatic wr(input int ch, input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    mgmt_wr[ch] = 1'b1;
    mgmt_addr[ch*5+:5] = a;
    mgmt_wdata[ch*16+:16] = d;
    @(negedge core_clk);
    mgmt_wr[ch] = 1'b0;
    @(negedge core_clk);
  endtask : wr
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  initial
  begin
    #200000;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    for (int ch = 0; ch < 4; ch++)
    begin
      chk("ctrl", qsanc_ctrl_reset, ctrl_value[ch*16+:16]);
      chk("advert", qsanc_advert_reset, autoneg_advert[ch*16+:16]);
    end
    $display("test reset done");
    for (int i = 0; i < 8; i++)
      for (int ch = 0; ch < 4; ch++)
      begin
        v = rnd();
        u_far.pulse(0, ch, v, i[0]);
        pd0 = pd0 | ((ch == 0) & v[2]);
        chk("unidir", v[0], unidir_enable[ch]);
        chk("isolate", v[3], gmii_isolate[ch]);
        chk("an_enable", v[4], an_enable[ch]);
        chk("power_down", (ch == 0) ? pd0 : 1'b0, power_down[ch]);
        chk("nm_unidir", config_bus[ch*6], nm_unidir[ch]);
        chk("nm_isolate", config_bus[ch*6+3], nm_iso[ch]);
      end
    $display("test config done");
    for (int ch = 0; ch < 4; ch++)
    begin
      v = rnd();
      fork
        u_far.pulse(1, ch, v, 1'b0);
        wr(ch, qsanc_advert_offset, ~v);
      join
      chk("advert", v | 16'h0001, autoneg_advert[ch*16+:16]);
      chk("nm_advert", v | 16'h0001, nm_advert[ch*16+:16]);
    end
    $display("test advert done");
    for (int ch = 1; ch < 4; ch++)
    begin
      n = 1 + int'(rnd() % 3);
      link_timer_value[ch*9+:9] = n[8:0];
      wr(ch, qsanc_ctrl_offset, 16'h1001);
      c = 0;
      fork
        u_far.pulse(2, ch, 16'h0000, 1'b0);
        begin
          for (int k = 0; k < 6 && an_busy[ch] !== 1'b1; k++)
            @(negedge core_clk);
          while (an_busy[ch] === 1'b1 && c < 100)
          begin
            c++;
            @(negedge core_clk);
          end
        end
      join
      @(negedge core_clk);
      chk("busy_len", 16'(n * tu + 1), c[15:0]);
      chk("irq", 1'b1, negotiation_done_irq[ch]);
      chk("done_level", config_bus[ch*6+4], nm_irq[ch]);
      wr(ch, qsanc_ctrl_offset, 16'h1000);
      chk("irq_masked", 1'b0, negotiation_done_irq[ch]);
      wr(ch, qsanc_ctrl_offset, 16'h1001);
      chk("irq_unmasked", 1'b1, negotiation_done_irq[ch]);
      wr(ch, qsanc_ctrl_offset, 16'h1003);
      chk("irq_cleared", 1'b0, negotiation_done_irq[ch]);
    end
    $display("test restart done");
    summarize();
  end
endmodule : qsanc_config_port_tb

// File: qsanc_pkg.sv
package qsanc_pkg;
  localparam int qsanc_channels = 4;
  localparam logic [4:0] qsanc_ctrl_offset = 5'h00;
  localparam logic [4:0] qsanc_advert_offset = 5'h04;
  localparam int qsanc_cfg_unidir_bit = 0;
  localparam int qsanc_cfg_power_down_bit = 2;
  localparam int qsanc_cfg_isolate_bit = 3;
  localparam int qsanc_cfg_an_enable_bit = 4;
  localparam int qsanc_ctrl_restart_bit = 9;
  localparam int qsanc_ctrl_an_enable_bit = 12;
  localparam int qsanc_ctrl_power_down_bit = 11;
  localparam int qsanc_ctrl_isolate_bit = 10;
  localparam int qsanc_ctrl_unidir_bit = 5;
  localparam int qsanc_ctrl_irq_enable_bit = 0;
  localparam int qsanc_ctrl_irq_clear_bit = 1;
  localparam logic [15:0] qsanc_ctrl_reset = 16'h1000;
  localparam logic [15:0] qsanc_advert_reset = 16'h0001;
  localparam logic [15:0] qsanc_advert_mac_mode = 16'h0001;
  localparam int qsanc_adv_always_one_bit = 0;
  localparam int qsanc_timer_unit_cycles = 4096;
  localparam int qsanc_clk_period_ns = 8;
  localparam int qsanc_timer_width = 9;
  localparam int qsanc_timer_unit_ns = qsanc_timer_unit_cycles * qsanc_clk_period_ns;
  localparam int qsanc_timer_unit_count = qsanc_timer_unit_ns / qsanc_clk_period_ns;
endpackage : qsanc_pkg
